// *** design/lsd_sink.sv ***
// lsd_sink: 16-channel led sink driver logic with fault detection
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// two-flop synchroniser
// ----------------------------------------------------------------
module lsd_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg <= INIT;
            q_reg <= INIT;
        end else begin
            meta_reg <= d_in;
            q_reg <= meta_reg;
        end
    end

    assign q_out = q_reg;
endmodule : lsd_sync

// ----------------------------------------------------------------
// driver core
// ----------------------------------------------------------------
module lsd_sink
    import lsd_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    lsd_if.dev link,
    input wire logic [CHANNELS-1:0] open_low_in,
    input wire logic [CHANNELS-1:0] short_high_in,
    input wire logic temp_warn_in,
    input wire logic temp_shut_in,
    output logic [CHANNELS-1:0] sink_on_out,
    output logic low_current_out
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [7:0] pins_raw;
    logic [7:0] pins_s;
    logic [2*CHANNELS-1:0] cmp_s;

    assign pins_raw = {link.sclk, link.serial_in, link.strobe_in,
                       link.enable_n, link.detect_select,
                       link.out_edge_select, temp_warn_in, temp_shut_in};

    // enable_n resets high so nothing lights before the first sample
    lsd_sync #(.WIDTH(8), .INIT(8'h10)) u_pin_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in(pins_raw),
        .q_out(pins_s)
    );

    lsd_sync #(.WIDTH(2 * CHANNELS)) u_cmp_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in({short_high_in, open_low_in}),
        .q_out(cmp_s)
    );

    wire sclk_s = pins_s[7];
    wire din_s = pins_s[6];
    wire strobe_s = pins_s[5];
    wire enable_n_s = pins_s[4];
    wire detsel_s = pins_s[3];
    wire edge_sel_s = pins_s[2];
    wire warn_s = pins_s[1];
    wire shut_s = pins_s[0];

    // ------------------------------------------------------------
    // edge detection on synchronised pins
    // ------------------------------------------------------------
    logic sclk_prev_reg;
    logic strobe_prev_reg;
    logic detsel_prev_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_prev_reg <= 1'b0;
            strobe_prev_reg <= 1'b0;
            detsel_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= sclk_s;
            strobe_prev_reg <= strobe_s;
            detsel_prev_reg <= detsel_s;
        end
    end

    wire sclk_rise = sclk_s & ~sclk_prev_reg;
    wire sclk_fall = ~sclk_s & sclk_prev_reg;
    wire strobe_rise = strobe_s & ~strobe_prev_reg;
    // a short pulse leaves two level changes, one at each of its edges
    wire detsel_change = detsel_s ^ detsel_prev_reg;
    wire outputs_en = ~enable_n_s;

    // ------------------------------------------------------------
    // shift register, latch and detection
    // ------------------------------------------------------------
    logic [CHANNELS-1:0] shift_reg;
    logic [CHANNELS-1:0] latch_reg;
    logic detect_now_reg;
    logic smart_reg;
    logic fail_pending_reg;
    logic alarm_fault_reg;
    logic shutdown_reg;
    logic alarm_reg;
    logic serial_out_reg;

    // final settled level chooses the comparator set
    wire [CHANNELS-1:0] fault_sel = detsel_s ?
        cmp_s[2*CHANNELS-1:CHANNELS] :
        cmp_s[CHANNELS-1:0];
    wire [CHANNELS-1:0] tested =
        latch_reg & {CHANNELS{outputs_en}};
    // healthy tested bits read one, untested keep their image bit
    wire [CHANNELS-1:0] det_result =
        (shift_reg & ~tested) | (tested & ~fault_sel);
    wire any_fail = |(tested & fault_sel);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            shift_reg <= '0;
        end else if (sclk_rise) begin
            shift_reg <= {shift_reg[CHANNELS-2:0], din_s};
        end else if (detect_now_reg) begin
            shift_reg <= det_result;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            latch_reg <= '0;
        end else if (strobe_rise) begin
            latch_reg <= shift_reg;
        end else if (detsel_change && outputs_en) begin
            latch_reg <= '1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            detect_now_reg <= 1'b0;
            smart_reg <= 1'b0;
        end else begin
            detect_now_reg <= strobe_rise | (detsel_change & outputs_en);
            // a select change in the strobe cycle still arms smart mode
            smart_reg <= detsel_change |
                (smart_reg & ~strobe_rise);
        end
    end

    assign low_current_out = smart_reg;

    // ------------------------------------------------------------
    // alarm and thermal handling
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fail_pending_reg <= 1'b0;
            alarm_fault_reg <= 1'b0;
        end else if (strobe_rise) begin
            fail_pending_reg <= 1'b0;
            alarm_fault_reg <= 1'b0;
        end else begin
            fail_pending_reg <= fail_pending_reg | any_fail;
            if (sclk_rise && fail_pending_reg) begin
                alarm_fault_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            shutdown_reg <= 1'b0;
        end else if (shut_s) begin
            shutdown_reg <= 1'b1;
        end else if (!warn_s) begin
            shutdown_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            alarm_reg <= 1'b0;
        end else begin
            alarm_reg <= alarm_fault_reg | warn_s | shut_s |
                shutdown_reg;
        end
    end

    assign link.alarm_pull = alarm_reg;

    // ------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            serial_out_reg <= 1'b0;
        end else if (sclk_rise && !edge_sel_s) begin
            serial_out_reg <= shift_reg[CHANNELS-2];
        end else if (sclk_fall && edge_sel_s) begin
            serial_out_reg <= shift_reg[CHANNELS-1];
        end else if (detect_now_reg && !sclk_rise) begin
            serial_out_reg <= det_result[CHANNELS-1];
        end
    end

    assign link.serial_out = serial_out_reg;

    // ------------------------------------------------------------
    // channel drive with staggered turn-on
    // ------------------------------------------------------------
    wire [CHANNELS-1:0] drive_req = latch_reg &
        {CHANNELS{outputs_en & ~shutdown_reg}};

    // turn-off is immediate; only turn-on is spread out
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        localparam int UNITS = STAGGER_GROUP - 1 - (ch % STAGGER_GROUP);
        localparam logic [RAMP_W-1:0] TARGET =
            RAMP_W'(UNITS * STAGGER_UNIT_CYCLES);
        logic [RAMP_W-1:0] ramp_reg;
        // own flop per channel: no two processes write one vector
        logic on_reg;

        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                ramp_reg <= '0;
                on_reg <= 1'b0;
            end else begin
                if (!drive_req[ch]) begin
                    ramp_reg <= '0;
                end else if (ramp_reg != TARGET) begin
                    ramp_reg <= ramp_reg + 1'b1;
                end
                on_reg <= drive_req[ch] &&
                    (ramp_reg == TARGET);
            end
        end

        assign sink_on_out[ch] = on_reg;
    end
endmodule : lsd_sink
`default_nettype wire

// *** include/lsd_pkg.sv ***
// lsd_pkg: shared constants and types for the led sink link
package lsd_pkg;
    // ------------------------------------------------------------
    // geometry and clock
    // ------------------------------------------------------------
    localparam int CHANNELS = 16;
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCLK_HZ = 2_500_000;
    localparam int SCLK_HALF_CYCLES = CLK_HZ / (2 * SCLK_HZ);
    localparam int HALF_W = 8;
    localparam logic [HALF_W-1:0] HALF_LAST =
        HALF_W'(SCLK_HALF_CYCLES - 1);
    localparam logic [3:0] LAST_BIT = 4'hf;
    // ------------------------------------------------------------
    // staggered turn-on
    // ------------------------------------------------------------
    localparam int STAGGER_UNIT_NS = 2;
    localparam int STAGGER_RAW =
        (STAGGER_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STAGGER_UNIT_CYCLES = (STAGGER_RAW < 1) ? 1 : STAGGER_RAW;
    localparam int STAGGER_GROUP = 8;
    localparam int RAMP_W = 6;
    // ------------------------------------------------------------
    // controller register map (apb byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PATTERN = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_READBACK = 8'h10;
    localparam logic [7:0] REG_FAIL = 8'h14;
    localparam int CTRL_ENABLE_N_BIT = 0;
    localparam int CTRL_DETECT_BIT = 1;
    localparam int CTRL_EDGE_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h1;
    localparam int CMD_START_BIT = 0;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_ALARM_BIT = 1;
    // ------------------------------------------------------------
    // controller states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_LOW = 5'h02,
        ST_HIGH = 5'h04,
        ST_GAP = 5'h08,
        ST_STROBE = 5'h10
    } lsd_state_type;
endpackage : lsd_pkg

// *** include/lsd_if.sv ***
// lsd_if: pins between display controller and led sink driver
`timescale 1ns/100ps
`default_nettype none
interface lsd_if;
    logic sclk;
    logic serial_in;
    logic strobe_in;
    logic enable_n;
    logic detect_select;
    logic out_edge_select;
    logic serial_out;
    logic alarm_pull;
    logic alarm_n;
    // open-drain alarm with pull-up: low only while the driver pulls
    assign alarm_n = ~alarm_pull;
    modport dev (
        input sclk, serial_in, strobe_in, enable_n,
        input detect_select, out_edge_select,
        output serial_out, alarm_pull
    );
    modport ctl (
        output sclk, serial_in, strobe_in, enable_n,
        output detect_select, out_edge_select,
        input serial_out, alarm_n
    );
endinterface : lsd_if
`default_nettype wire

// *** design/lsd_ctrl.sv ***
// lsd_ctrl: apb-controlled display controller end of the led link
`timescale 1ns/100ps
`default_nettype none
module lsd_ctrl
    import lsd_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    lsd_if.ctl link
);
    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic [2:0] ctrl_reg;
    logic [CHANNELS-1:0] pattern_reg;
    logic [CHANNELS-1:0] cur_sent_reg;
    logic [CHANNELS-1:0] prev_sent_reg;
    logic [CHANNELS-1:0] rb_shift_reg;
    logic [CHANNELS-1:0] readback_reg;
    logic [31:0] prdata_reg;
    logic alarm_s;
    lsd_state_type state_reg;

    wire hit_ctrl = paddr_in == REG_CTRL;
    wire hit_pattern = paddr_in == REG_PATTERN;
    wire hit_cmd = paddr_in == REG_CMD;
    wire hit_status = paddr_in == REG_STATUS;
    wire hit_rb = paddr_in == REG_READBACK;
    wire hit_fail = paddr_in == REG_FAIL;
    wire mapped = hit_ctrl | hit_pattern | hit_cmd | hit_status |
        hit_rb | hit_fail;
    wire setup = psel_in & ~penable_in;
    wire access = psel_in & penable_in;
    wire wr = access & pwrite_in & mapped;
    wire busy = state_reg != ST_IDLE;
    // a start while a frame runs is dropped
    wire start = wr & hit_cmd & pwdata_in[CMD_START_BIT] & ~busy;
    // one-to-zero against what was sent flags a failed led
    wire [CHANNELS-1:0] fail_mask =
        prev_sent_reg & ~readback_reg;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        if (hit_ctrl) begin
            rd_mux = {29'h0, ctrl_reg};
        end else if (hit_pattern) begin
            rd_mux = {16'h0, pattern_reg};
        end else if (hit_status) begin
            rd_mux = {30'h0, alarm_s, busy};
        end else if (hit_rb) begin
            rd_mux = {16'h0, readback_reg};
        end else if (hit_fail) begin
            rd_mux = {16'h0, fail_mask};
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_reg <= CTRL_RESET;
            pattern_reg <= '0;
            prdata_reg <= 32'h0;
        end else begin
            if (setup && !pwrite_in) begin
                prdata_reg <= rd_mux;
            end
            if (wr && hit_ctrl) begin
                ctrl_reg <= pwdata_in[2:0];
            end
            if (wr && hit_pattern) begin
                pattern_reg <= pwdata_in[CHANNELS-1:0];
            end
        end
    end

    assign prdata_out = prdata_reg;
    assign pready_out = 1'b1;
    assign pslverr_out = access & ~mapped;

    // ------------------------------------------------------------
    // alarm input
    // ------------------------------------------------------------
    logic [1:0] link_s;

    lsd_sync #(.WIDTH(2), .INIT(2'h2)) u_link_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .d_in({link.alarm_n, link.serial_out}),
        .q_out(link_s)
    );

    // status shows the raw condition; software splits it by mode
    assign alarm_s = ~link_s[1];

    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    logic [HALF_W-1:0] half_reg;
    logic [3:0] bit_reg;
    logic [CHANNELS-1:0] tx_reg;
    logic sclk_reg;
    logic strobe_reg;
    wire half_done = half_reg == HALF_LAST;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            half_reg <= '0;
        end else if (!busy || half_done) begin
            half_reg <= '0;
        end else begin
            half_reg <= half_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= ST_IDLE;
            bit_reg <= 4'h0;
            tx_reg <= '0;
            sclk_reg <= 1'b0;
            strobe_reg <= 1'b0;
            cur_sent_reg <= '0;
            prev_sent_reg <= '0;
            rb_shift_reg <= '0;
            readback_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        tx_reg <= pattern_reg;
                        prev_sent_reg <= cur_sent_reg;
                        cur_sent_reg <= pattern_reg;
                        bit_reg <= 4'h0;
                        state_reg <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (half_done) begin
                        // previous result read while new image goes in
                        rb_shift_reg <= {rb_shift_reg[CHANNELS-2:0],
                            link_s[0]};
                        sclk_reg <= 1'b1;
                        state_reg <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (half_done) begin
                        sclk_reg <= 1'b0;
                        if (bit_reg == LAST_BIT) begin
                            state_reg <= ST_GAP;
                        end else begin
                            bit_reg <= bit_reg + 1'b1;
                            tx_reg <= {tx_reg[CHANNELS-2:0], 1'b0};
                            state_reg <= ST_LOW;
                        end
                    end
                end
                ST_GAP: begin
                    if (half_done) begin
                        strobe_reg <= 1'b1;
                        state_reg <= ST_STROBE;
                    end
                end
                ST_STROBE: begin
                    if (half_done) begin
                        strobe_reg <= 1'b0;
                        readback_reg <= rb_shift_reg;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign link.sclk = sclk_reg;
    assign link.serial_in = tx_reg[CHANNELS-1];
    assign link.strobe_in = strobe_reg;
    // software pwm on enable and select toggles act at once
    assign link.enable_n = ctrl_reg[CTRL_ENABLE_N_BIT];
    assign link.detect_select = ctrl_reg[CTRL_DETECT_BIT];
    assign link.out_edge_select = ctrl_reg[CTRL_EDGE_BIT];
endmodule : lsd_ctrl
`default_nettype wire

// *** sim/lsd_monitor.sv ***
// lsd_monitor: timing checks on the led sink link pins
`timescale 1ns/100ps
`default_nettype none
module lsd_monitor
    import lsd_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic strobe_in,
    input wire logic enable_n,
    input wire logic detect_select,
    input wire logic out_edge_select,
    input wire logic serial_out,
    input wire logic alarm_n,
    input wire logic temp_warn_in,
    input wire logic temp_shut_in,
    input wire logic [CHANNELS-1:0] sink_on_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ----
    // link checks
    // ----
    a_strobe_after_fall: assert property (
        $rose(strobe_in) |-> !sclk && !$past(sclk, 5))
        else $error("strobe rose too close to clock");
    a_data_held_high: assert property (
        sclk && $past(sclk) |-> $stable(serial_in))
        else $error("serial data moved while clock high");
    a_strobe_width: assert property (
        $rose(strobe_in) |-> strobe_in [*8])
        else $error("strobe pulse too short");
    // smart refresh after a select change is excluded
    a_out_rise_edge: assert property (
        !out_edge_select && !strobe_in && $changed(serial_out)
        && $past(detect_select, 6) == detect_select |-> sclk)
        else $error("serial out moved outside clock high");
    a_out_fall_edge: assert property (
        out_edge_select && !strobe_in && $changed(serial_out)
        && $past(detect_select, 6) == detect_select |-> !sclk)
        else $error("serial out moved outside clock low");
    a_alarm_release: assert property (
        $rose(strobe_in) && !temp_warn_in && !temp_shut_in
        |-> ##[1:8] alarm_n)
        else $error("alarm not released after strobe");
    a_warn_alarm: assert property (
        temp_warn_in [*5] |-> !alarm_n)
        else $error("alarm not pulled on warning");
    a_shut_off: assert property (
        temp_shut_in [*5] |-> sink_on_out == 16'h0000)
        else $error("channels on during shutdown");
    a_enable_gate: assert property (
        enable_n [*6] |-> sink_on_out == 16'h0000)
        else $error("channels on while disabled");
endmodule : lsd_monitor
`default_nettype wire

// *** sim/lsd_tb_top.sv ***
// lsd_tb_top: self-checking bench for controller and sink driver
`timescale 1ns/100ps
`default_nettype none
module lsd_tb_top
    import lsd_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] open_low = 16'h0081;
    logic [15:0] short_high = 16'h0100;
    logic temp_warn = 1'b0;
    logic temp_shut = 1'b0;
    logic [15:0] sink_on;
    logic low_cur;
    logic [31:0] rd;
    logic err_seen;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    lsd_if link();
    always #10 clk_in = ~clk_in;
    lsd_sink i_lsd_sink (.clk_in(clk_in), .rst_in(rst_in), .link(link),
        .open_low_in(open_low), .short_high_in(short_high),
        .temp_warn_in(temp_warn), .temp_shut_in(temp_shut),
        .sink_on_out(sink_on), .low_current_out(low_cur));
    lsd_ctrl i_lsd_ctrl (.clk_in(clk_in), .rst_in(rst_in),
        .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .link(link));
    lsd_monitor i_lsd_monitor (.clk_in(clk_in), .rst_in(rst_in),
        .sclk(link.sclk), .serial_in(link.serial_in),
        .strobe_in(link.strobe_in), .enable_n(link.enable_n),
        .detect_select(link.detect_select),
        .out_edge_select(link.out_edge_select),
        .serial_out(link.serial_out), .alarm_n(link.alarm_n),
        .temp_warn_in(temp_warn), .temp_shut_in(temp_shut),
        .sink_on_out(sink_on));
    // ----
    // shared tasks
    // ----
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic final_report();
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_in);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1'b1;
        do @(posedge clk_in); while (pready !== 1'b1);
        q = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr
    // alarm is judged mid-frame, after the first clock rise
    task automatic frame(input logic [15:0] pat, input logic alm);
        int n;
        n = 0;
        wr(REG_PATTERN, {16'h0000, pat});
        wr(REG_CMD, 32'h00000001);
        repeat (40) @(posedge clk_in);
        apb(1'b0, REG_STATUS, 32'h0, rd);
        check("alarm", {31'h0, alm}, {31'h0, rd[STATUS_ALARM_BIT]});
        do begin
            apb(1'b0, REG_STATUS, 32'h0, rd);
            n++;
        end while (rd[STATUS_BUSY_BIT] !== 1'b0 && n < 200);
        check("busy", 32'h0, {31'h0, rd[STATUS_BUSY_BIT]});
        repeat (14) @(posedge clk_in);
    endtask : frame
    task automatic readback(input logic [15:0] exp);
        apb(1'b0, REG_READBACK, 32'h0, rd);
        check("readback", {16'h0000, exp}, rd);
    endtask : readback
    // ----
    // scenarios
    // ----
    task automatic t_reset();
        apb(1'b0, REG_CTRL, 32'h0, rd);
        check("ctrl reset", {29'h0, CTRL_RESET}, rd);
        apb(1'b0, 8'h20, 32'h0, rd);
        check("unmapped err", 32'h1, {31'h0, err_seen});
        check("unmapped data", 32'h0, rd);
        check("sink reset", 32'h0, {16'h0000, sink_on});
        $display("reset test done");
    endtask : t_reset
    task automatic t_open();
        wr(REG_CTRL, 32'h0);
        frame(16'ha5f1, 1'b0);
        check("sink on", 32'ha5f1, {16'h0000, sink_on});
        frame(16'h0000, 1'b1);
        readback(16'ha570);
        apb(1'b0, REG_FAIL, 32'h0, rd);
        check("fail map", 32'h0081, rd);
        $display("open detect test done");
    endtask : t_open
    task automatic t_smart();
        wr(REG_CTRL, 32'h6);
        repeat (14) @(posedge clk_in);
        check("all on", 32'hffff, {16'h0000, sink_on});
        check("low cur", 32'h1, {31'h0, low_cur});
        frame(16'h3c3c, 1'b1);
        readback(16'hfeff);
        check("cur back", 32'h0, {31'h0, low_cur});
        check("new latch", 32'h3c3c, {16'h0000, sink_on});
        $display("smart detect test done");
    endtask : t_smart
    task automatic t_disabled();
        wr(REG_CTRL, 32'h1);
        repeat (14) @(posedge clk_in);
        check("gated", 32'h0, {16'h0000, sink_on});
        frame(16'hffff, 1'b0);
        readback(16'h3c3c);
        frame(16'h5a5a, 1'b0);
        readback(16'hffff);
        $display("disabled test done");
    endtask : t_disabled
    task automatic t_thermal();
        wr(REG_CTRL, 32'h0);
        temp_warn <= 1'b1;
        repeat (14) @(posedge clk_in);
        check("warn on", 32'h5a5a, {16'h0000, sink_on});
        apb(1'b0, REG_STATUS, 32'h0, rd);
        check("warn alarm", 32'h2, rd & 32'h2);
        temp_shut <= 1'b1;
        repeat (10) @(posedge clk_in);
        temp_shut <= 1'b0;
        repeat (10) @(posedge clk_in);
        check("still off", 32'h0, {16'h0000, sink_on});
        temp_warn <= 1'b0;
        repeat (14) @(posedge clk_in);
        check("restart", 32'h5a5a, {16'h0000, sink_on});
        apb(1'b0, REG_STATUS, 32'h0, rd);
        check("alarm off", 32'h0, rd & 32'h2);
        $display("thermal test done");
    endtask : t_thermal
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_open();
        t_smart();
        t_disabled();
        t_thermal();
        final_report();
    end
endmodule : lsd_tb_top
`default_nettype wire
